// ==== common/tdc_defines.vh ====
// Constants for the trigger and display command handler
`ifndef TDC_DEFINES_VH
`define TDC_DEFINES_VH
// Command opcodes, one code per command whatever its spelling
`define TDC_OP_NONE 4'h0
`define TDC_OP_ABORT 4'h1
`define TDC_OP_CONTRAST 4'h2
`define TDC_OP_DMODE 4'h3
`define TDC_OP_DTEXT 4'h4
`define TDC_OP_INIT 4'h5
`define TDC_OP_INITCONT 4'h6
`define TDC_OP_INSTSTAT 4'h7
`define TDC_OP_OUTSTAT 4'h8
`define TDC_OP_RESET 4'h9
`define TDC_OP_TRG 4'hA
`define TDC_OP_VOLTIMM 4'hB
`define TDC_OP_CURRIMM 4'hC
`define TDC_OP_VOLTTRIG 4'hD
`define TDC_OP_CURRTRIG 4'hE
// Largest argument of the contrast command
`define TDC_CON_MAX 4'h9
// Parameter values for mode and continuous commands
`define TDC_ARG_NORMAL 16'h0000
`define TDC_ARG_TEXT 16'h0001
// Display line length in characters
`define TDC_TEXT_LEN 16
// Reset values
`define TDC_RST_CONTRAST 4'h5
`define TDC_RST_LEVEL 16'h0000
// Query answer codes for the display mode
`define TDC_ANS_NORMAL 1'b0
`define TDC_ANS_TEXT 1'b1
// Blank character shown in place of a refused one
`define TDC_CHAR_BLANK 8'h20
`endif

// ==== tb/tdc_cmd_handler_bench.sv ====
// Self-checking bench for the command handler
`timescale 1ns/1ps
`include "tdc_defines.vh"
module tdc_cmd_handler_bench;
  reg clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, trig_done = 1'b0;
  reg cmd_frac = 1'b0; // Contrast form marker, randomised
  reg [127:0] meter_line = 128'h0; // Monitored line, randomised
  wire cmd_valid;
  wire [3:0] cmd_op;
  wire [15:0] cmd_arg;
  wire [127:0] cmd_text, display_line_q, text_answer_q;
  wire [7:0] cmd_text_len;
  wire [15:0] volt_out_q, curr_out_q, volt_trig_q, curr_trig_q;
  wire [3:0] contrast_q;
  wire waiting_for_trigger_flag_q, cont_trig_q, output_on_q, nv_write_q;
  wire display_text_mode_q, text_quoted_q, cmd_error_q, trig_pulse_q;
  reg [15:0] vi = 0, ii = 0, vt = 0, it = 0; // Model levels
  reg wt = 0, cn = 0, md = 0, ou = 0; // Model flags
  reg [3:0] co = `TDC_RST_CONTRAST; // Model contrast
  reg [7:0] tl = 8'd20; // Characters sent with a string
  reg [127:0] tx = 0, txt = 0; // Sent text and shown text
  reg [31:0] lf = 32'h9194; // Random source
  integer failures = 0, cmp_count = 0, k;
  string s = "DO NOTaTOUCH<>+-/=:.9Z";
  always #5 clk = ~clk;
  tdc_cmd_handler tdc_cmd_handler_inst (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_frac(cmd_frac),
    .cmd_text(cmd_text), .cmd_text_len(cmd_text_len),
    .meter_line(meter_line), .trig_done(trig_done),
    .volt_out_q(volt_out_q), .curr_out_q(curr_out_q),
    .volt_trig_q(volt_trig_q), .curr_trig_q(curr_trig_q),
    .waiting_for_trigger_flag_q(waiting_for_trigger_flag_q),
    .cont_trig_q(cont_trig_q), .output_on_q(output_on_q),
    .display_text_mode_q(display_text_mode_q), .contrast_q(contrast_q),
    .nv_write_q(nv_write_q), .display_line_q(display_line_q),
    .text_answer_q(text_answer_q), .text_quoted_q(text_quoted_q),
    .cmd_error_q(cmd_error_q), .trig_pulse_q(trig_pulse_q));
  tdc_ctrl_model tdc_ctrl_model_inst (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
    .cmd_text(cmd_text), .cmd_text_len(cmd_text_len));
  // Next random value
  function [15:0] rnd;
    begin
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      rnd = lf[15:0];
    end
  endfunction
  // Refused characters show as a blank
  function [7:0] vis(input [7:0] c);
    vis = ((c >= "A" && c <= "Z") || (c >= "0" && c <= "9") || c == " " ||
      c == "<" || c == ">" || c == "+" || c == "-" || c == "/" ||
      c == "=" || c == ":" || c == ".") ? c : `TDC_CHAR_BLANK;
  endfunction
  task chk(input [128:0] got, input [128:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Issue one command, update the model, compare everything
  task run(input [3:0] op, input [15:0] arg);
    reg [2:0] p, ep;
    integer j;
    begin
      // A frozen block keeps its captured meter line
      if (clk_en) meter_line = {rnd(), rnd(), rnd(), rnd(),
        rnd(), rnd(), rnd(), rnd()};
      cmd_frac = lf[3];
      tdc_ctrl_model_inst.send(op, arg, tx, tl);
      p = {trig_pulse_q, nv_write_q, cmd_error_q};
      ep = 3'b000;
      if (clk_en) case (op)
        `TDC_OP_VOLTIMM: vi = arg;
        `TDC_OP_CURRIMM: ii = arg;
        `TDC_OP_VOLTTRIG: vt = arg;
        `TDC_OP_CURRTRIG: it = arg;
        `TDC_OP_ABORT: {vt, it, wt} = {vi, ii, 1'b0};
        `TDC_OP_INIT: wt = 1'b1;
        `TDC_OP_TRG: if (wt) {vi, ii, ep[2], wt} = {vt, it, 1'b1, cn};
        `TDC_OP_INITCONT: if (arg < 2) cn = arg[0];
        `TDC_OP_RESET: {cn, md} = 2'b00;
        `TDC_OP_OUTSTAT, `TDC_OP_INSTSTAT: ou = arg[0];
        `TDC_OP_DMODE: if (arg < 2) md = arg[0]; else ep[0] = 1'b1;
        `TDC_OP_CONTRAST: if (arg < 10) {co, ep[1]} = {arg[3:0], 1'b1};
          else ep[0] = 1'b1;
        `TDC_OP_DTEXT: for (j = 0; j < 16; j++)
          txt[8*j +: 8] = (j < tl) ? vis(s[j]) : `TDC_CHAR_BLANK;
        default: ;
      endcase
      if (cn) wt = 1'b1;
      if (trig_done && !cn) wt = 1'b0; // Completed single cycle idles
      chk(p, ep);
      repeat (4) @(negedge clk);
      chk({volt_out_q, curr_out_q, volt_trig_q, curr_trig_q},
        {vi, ii, vt, it});
      chk({waiting_for_trigger_flag_q, cont_trig_q, display_text_mode_q,
        output_on_q, contrast_q}, {wt, cn, md, ou, co});
      if (md) chk({text_quoted_q, text_answer_q}, {1'b1, txt});
      if (md) chk(display_line_q, txt);
      if (!md) chk({text_quoted_q, text_answer_q},
        {1'b0, meter_line});
      if (!md) chk(display_line_q, meter_line);
    end
  endtask
  task end_sim;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    failures = failures + 1;
    end_sim;
  end
  // Main sequence
  initial begin
    for (k = 0; k < 16; k++) tx[8*k +: 8] = s[k];
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    run(`TDC_OP_NONE, 16'h0000);
    repeat (3) begin
      run(`TDC_OP_VOLTIMM, rnd());
      run(`TDC_OP_CURRIMM, rnd());
      run(`TDC_OP_VOLTTRIG, rnd());
      run(`TDC_OP_CURRTRIG, rnd());
      run(`TDC_OP_TRG, 16'h0000);
      run(`TDC_OP_INIT, 16'h0000);
      run(`TDC_OP_TRG, 16'h0000);
      run(`TDC_OP_TRG, 16'h0000);
      run(`TDC_OP_VOLTTRIG, rnd());
      run(`TDC_OP_ABORT, 16'h0000);
    end
    resetn = 1'b0; // Second power-on in mid-run
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    {vi, ii, vt, it} = 64'h0;
    {wt, cn, md, ou, co, txt} = {4'h0, `TDC_RST_CONTRAST, 128'h0};
    run(`TDC_OP_NONE, 16'h0000);
    run(`TDC_OP_INITCONT, 16'h0001);
    run(`TDC_OP_TRG, 16'h0000);
    run(`TDC_OP_ABORT, 16'h0000);
    run(`TDC_OP_INITCONT, 16'h0005);
    run(`TDC_OP_RESET, 16'h0000);
    run(`TDC_OP_INITCONT, 16'h0001);
    run(`TDC_OP_INITCONT, 16'h0000);
    trig_done = 1'b1; // Output stage reports the cycle complete
    run(`TDC_OP_NONE, 16'h0000);
    trig_done = 1'b0;
    clk_en = 1'b0; // Frozen: the command must leave no trace
    run(`TDC_OP_VOLTIMM, 16'h1234);
    clk_en = 1'b1;
    for (k = 0; k < 11; k++) run(`TDC_OP_CONTRAST, k[15:0]);
    run(`TDC_OP_CONTRAST, 16'h0103);
    run(`TDC_OP_DMODE, 16'h0002);
    run(`TDC_OP_DMODE, `TDC_ARG_TEXT);
    run(`TDC_OP_DTEXT, 16'h0000);
    tl = 8'd5; // Fewer characters than the line holds
    run(`TDC_OP_DTEXT, 16'h0000);
    tl = 8'd20;
    run(`TDC_OP_DMODE, `TDC_ARG_NORMAL);
    run(`TDC_OP_DMODE, `TDC_ARG_TEXT);
    run(`TDC_OP_RESET, 16'h0000);
    run(`TDC_OP_OUTSTAT, 16'h0001);
    run(`TDC_OP_INSTSTAT, 16'h0000);
    run(`TDC_OP_INSTSTAT, 16'h0001);
    end_sim;
  end
endmodule // tdc_cmd_handler_bench

// ==== tb/tdc_cmd_handler_monitor.sv ====
// Assertion checker for the command handler
`timescale 1ns/1ps
`include "tdc_defines.vh"
module tdc_cmd_handler_monitor (
  input wire clk,
  input wire resetn,
  input wire clk_en,
  input wire cmd_valid,
  input wire [3:0] cmd_op,
  input wire [15:0] cmd_arg,
  input wire [15:0] volt_out_q,
  input wire [15:0] curr_out_q,
  input wire [15:0] volt_trig_q,
  input wire [15:0] curr_trig_q,
  input wire waiting_for_trigger_flag_q,
  input wire cont_trig_q,
  input wire output_on_q,
  input wire display_text_mode_q,
  input wire [3:0] contrast_q,
  input wire nv_write_q,
  input wire cmd_error_q,
  input wire trig_pulse_q
);
  wire go = clk_en & cmd_valid; // Command taken at this edge
  wire wt = waiting_for_trigger_flag_q; // Armed flag
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_abort_copy_levels: assert property (
    go && cmd_op == `TDC_OP_ABORT |=> !wt &&
    volt_trig_q == $past(volt_out_q) && curr_trig_q == $past(curr_out_q))
    else $error("abort did not restore pending levels");
  a_init_arms: assert property (
    go && cmd_op == `TDC_OP_INIT |=> wt) else $error("init did not arm");
  a_trig_applies: assert property (
    go && cmd_op == `TDC_OP_TRG && wt |=> trig_pulse_q &&
    volt_out_q == $past(volt_trig_q) && curr_out_q == $past(curr_trig_q))
    else $error("trigger did not apply pending levels");
  a_trig_idle_ignored: assert property (
    go && cmd_op == `TDC_OP_TRG && !wt |=> !trig_pulse_q && $stable(volt_out_q))
    else $error("trigger fired while idle");
  a_single_idles: assert property (
    go && cmd_op == `TDC_OP_TRG && wt && !cont_trig_q |=> !wt)
    else $error("single trigger did not return to idle");
  a_cont_stays_armed: assert property (
    go && cmd_op == `TDC_OP_TRG && wt && cont_trig_q |=> wt [*3])
    else $error("continuous trigger dropped the armed flag");
  a_contrast_store: assert property (
    go && cmd_op == `TDC_OP_CONTRAST && cmd_arg <= 16'h0009 |=>
    nv_write_q && contrast_q == $past(cmd_arg[3:0]))
    else $error("contrast not stored");
  a_contrast_refuse: assert property (
    go && cmd_op == `TDC_OP_CONTRAST && cmd_arg > 16'h0009 |=>
    cmd_error_q && !nv_write_q && $stable(contrast_q))
    else $error("bad contrast not refused");
  a_reset_cmd_clears: assert property (
    go && cmd_op == `TDC_OP_RESET |=> !cont_trig_q && !display_text_mode_q)
    else $error("reset command left settings");
  a_inst_alias: assert property (
    go && (cmd_op == `TDC_OP_INSTSTAT || cmd_op == `TDC_OP_OUTSTAT) |=>
    output_on_q == $past(cmd_arg[0])) else $error("output state wrong");
  c_trig: cover property (go && cmd_op == `TDC_OP_TRG && wt);
  c_abort: cover property (go && cmd_op == `TDC_OP_ABORT);
  c_refuse: cover property (cmd_error_q);
endmodule // tdc_cmd_handler_monitor
bind tdc_cmd_handler tdc_cmd_handler_monitor tdc_cmd_handler_monitor_inst (
  .clk(clk), .resetn(resetn), .clk_en(clk_en), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_arg(cmd_arg), .volt_out_q(volt_out_q),
  .curr_out_q(curr_out_q), .volt_trig_q(volt_trig_q),
  .curr_trig_q(curr_trig_q),
  .waiting_for_trigger_flag_q(waiting_for_trigger_flag_q),
  .cont_trig_q(cont_trig_q), .output_on_q(output_on_q),
  .display_text_mode_q(display_text_mode_q), .contrast_q(contrast_q),
  .nv_write_q(nv_write_q), .cmd_error_q(cmd_error_q),
  .trig_pulse_q(trig_pulse_q));

// ==== tb/tdc_ctrl_model.sv ====
// Remote controller model that issues decoded commands
`timescale 1ns/1ps
module tdc_ctrl_model (
  input wire clk,
  output reg cmd_valid,
  output reg [3:0] cmd_op,
  output reg [15:0] cmd_arg,
  output reg [127:0] cmd_text,
  output reg [7:0] cmd_text_len
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    cmd_arg = 16'hA5A5;
    cmd_text = 128'h0;
    cmd_text_len = 8'h00;
  end
  // One command for one cycle, either spelling maps to one code
  task send(input [3:0] op, input [15:0] arg, input [127:0] tx,
            input [7:0] tl);
    begin
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_arg = arg;
      cmd_text = tx;
      cmd_text_len = tl;
      @(negedge clk);
      cmd_valid = 1'b0;
      // Released op, argument and text lines do not keep the old value
      cmd_op = ~op;
      cmd_arg = ~arg;
      cmd_text = ~tx;
    end
  endtask
endmodule // tdc_ctrl_model

// ==== verilog/tdc_cmd_handler.v ====
// Trigger, output-state and display command handler
`timescale 1ns/1ps
`include "tdc_defines.vh"

module tdc_cmd_handler (
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // Command strobe from the parser; both spellings share one opcode
  input wire cmd_valid,
  input wire [3:0] cmd_op,
  input wire [15:0] cmd_arg,
  // Contrast form: 1 = fractional tenths, 0 = integer
  input wire cmd_frac,
  // Text string characters, index 0 first, and count received
  input wire [127:0] cmd_text,
  input wire [7:0] cmd_text_len,
  // Monitored second line from the metering logic (pin domain)
  input wire [127:0] meter_line,
  // Trigger cycle completion from the output stage (pin domain)
  input wire trig_done,
  // Outputs
  output reg [15:0] volt_out_q,
  output reg [15:0] curr_out_q,
  output reg [15:0] volt_trig_q,
  output reg [15:0] curr_trig_q,
  output reg waiting_for_trigger_flag_q,
  output reg cont_trig_q,
  output reg output_on_q,
  output reg display_text_mode_q,
  output reg [3:0] contrast_q,
  output reg nv_write_q,
  output reg [127:0] display_line_q,
  output reg [127:0] text_answer_q,
  output reg text_quoted_q,
  output reg cmd_error_q,
  output reg trig_pulse_q
);

  // -----------------------------------------------------------------
  // State and helpers
  // -----------------------------------------------------------------
  localparam ST_IDLE = 2'b01;  // Trigger system idle
  localparam ST_ARMED = 2'b10; // Waiting for trigger

  reg [1:0] st_q;            // Trigger state, one-hot
  reg [15:0] volt_imm_q;     // Immediate voltage level
  reg [15:0] curr_imm_q;     // Immediate current level
  reg [127:0] user_text_q;   // Stored user string
  reg por_q;                 // Power-on abort still to run
  reg done_s1_q;             // Synchroniser stage one
  reg done_s2_q;             // Synchroniser stage two
  reg done_s3_q;             // Last synchronised completion level
  reg [127:0] meter_s1_q;    // Meter line stage one
  reg [127:0] meter_s2_q;    // Meter line stage two
  reg [127:0] meter_s3_q;    // Meter line one sample later
  reg [127:0] meter_hold_q;  // Coherent copy of the meter line
  wire [127:0] text_kept;    // Filtered, truncated string
  wire do_cmd;
  wire is_trg;
  wire is_abort;
  wire done_rise;            // Completion edge, one cycle long
  wire meter_steady;         // Two equal samples in a row

  // Allowed characters: A-Z, 0-9, space, < > + - / = : .
  function char_ok;
    input [7:0] c;
    begin
      char_ok = (c >= 8'h41 && c <= 8'h5A) ||
                (c >= 8'h30 && c <= 8'h3A) ||
                c == 8'h20 || c == 8'h3C || c == 8'h3E ||
                c == 8'h2B || c == 8'h2D || c == 8'h2F ||
                c == 8'h3D || c == 8'h2E;
    end
  endfunction

  // Opcode match; both spellings already map to one code
  function op_is;
    input [3:0] op;
    input [3:0] want;
    begin
      op_is = (op == want);
    end
  endfunction

  assign do_cmd = clk_en & cmd_valid;
  assign is_trg = do_cmd & op_is(cmd_op, `TDC_OP_TRG);
  assign is_abort = (do_cmd & op_is(cmd_op, `TDC_OP_ABORT)) | por_q;

  // A completion level that stays high must act for one cycle only
  assign done_rise = done_s2_q & ~done_s3_q;
  // A word caught mid-change differs between samples; wait it out
  assign meter_steady = (meter_s2_q == meter_s3_q);

  // -----------------------------------------------------------------
  // String filter: first sixteen characters, refused ones blanked
  // -----------------------------------------------------------------
  // Cut length and refused characters are settled before storage, so
  // the query returns exactly what the second line shows.
  genvar gi;
  generate
    for (gi = 0; gi < `TDC_TEXT_LEN; gi = gi + 1) begin : g_chr
      wire [7:0] ch = cmd_text[gi*8 +: 8];
      // Characters past the received count or outside the set blank
      assign text_kept[gi*8 +: 8] =
        (gi < cmd_text_len && char_ok(ch)) ? ch
                                           : `TDC_CHAR_BLANK;
    end
  endgenerate

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  // Two flops on the pin-domain inputs
  // The third stages feed the edge and stability tests and the meter capture
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0; // Idle level, so no false edge after reset
      meter_s1_q <= 128'h0;
      meter_s2_q <= 128'h0;
      meter_s3_q <= 128'h0;
    end else if (clk_en) begin
      done_s1_q <= trig_done;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      meter_s1_q <= meter_line;
      meter_s2_q <= meter_s1_q;
      meter_s3_q <= meter_s2_q;
    end
  end

  // -----------------------------------------------------------------
  // Meter line capture
  // -----------------------------------------------------------------
  // Each of the 128 bits is synchronised alone, so a sample taken
  // while the metering logic rewrites the line can mix old and new
  // characters. Only a value seen unchanged on two successive edges
  // is taken over; a line that never settles leaves the last
  // coherent one on show.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meter_hold_q <= 128'h0; // Blank line until the first capture
    end else if (clk_en) begin
      if (meter_steady) begin
        meter_hold_q <= meter_s3_q;
      end
    end
  end

  // -----------------------------------------------------------------
  // Levels and abort
  // -----------------------------------------------------------------
  // Immediate and pending levels; trigger applies pending levels
  // A trigger also makes the pending levels the new immediate ones,
  // so a later abort copies what the output really shows.
  // The power-on abort runs on the first enabled edge after reset.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      por_q <= 1'b1;
      volt_imm_q <= `TDC_RST_LEVEL;
      curr_imm_q <= `TDC_RST_LEVEL;
      volt_trig_q <= `TDC_RST_LEVEL;
      curr_trig_q <= `TDC_RST_LEVEL;
      volt_out_q <= `TDC_RST_LEVEL;
      curr_out_q <= `TDC_RST_LEVEL;
    end else if (clk_en) begin
      por_q <= 1'b0;
      if (do_cmd && op_is(cmd_op, `TDC_OP_VOLTIMM)) begin
        volt_imm_q <= cmd_arg;
        volt_out_q <= cmd_arg;
      end
      if (do_cmd && op_is(cmd_op, `TDC_OP_CURRIMM)) begin
        curr_imm_q <= cmd_arg;
        curr_out_q <= cmd_arg;
      end
      if (is_abort) begin
        // Pending levels replaced by immediate values
        volt_trig_q <= volt_imm_q;
        curr_trig_q <= curr_imm_q;
      end else begin
        if (do_cmd && op_is(cmd_op, `TDC_OP_VOLTTRIG)) begin
          volt_trig_q <= cmd_arg;
        end
        if (do_cmd && op_is(cmd_op, `TDC_OP_CURRTRIG)) begin
          curr_trig_q <= cmd_arg;
        end
      end
      if (is_trg && st_q == ST_ARMED && !is_abort) begin
        volt_out_q <= volt_trig_q;
        curr_out_q <= curr_trig_q;
        volt_imm_q <= volt_trig_q;
        curr_imm_q <= curr_trig_q;
      end
    end
  end

  // -----------------------------------------------------------------
  // Trigger state machine
  // -----------------------------------------------------------------
  // Armed by initiate or continuous mode; idle after a single cycle
  // Abort outranks initiate and trigger in the same cycle, so a
  // cancelled arming can never fire with stale pending levels.
  // With continuous mode on the flag returns the cycle after idle.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      waiting_for_trigger_flag_q <= 1'b0;
      cont_trig_q <= 1'b0;
      trig_pulse_q <= 1'b0;
    end else if (clk_en) begin
      trig_pulse_q <= 1'b0;
      // Continuous setting: only 0 and 1 are taken, others ignored
      if (do_cmd && op_is(cmd_op, `TDC_OP_INITCONT)) begin
        if (cmd_arg == 16'h0001) begin
          cont_trig_q <= 1'b1;
        end else if (cmd_arg == 16'h0000) begin
          cont_trig_q <= 1'b0;
        end
      end
      if (do_cmd && op_is(cmd_op, `TDC_OP_RESET)) begin
        cont_trig_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (!is_abort && (cont_trig_q ||
              (do_cmd && op_is(cmd_op, `TDC_OP_INIT)))) begin
            st_q <= ST_ARMED;
            waiting_for_trigger_flag_q <= 1'b1;
          end
        end
        ST_ARMED: begin
          if (is_abort) begin
            st_q <= ST_IDLE;
            waiting_for_trigger_flag_q <= 1'b0;
          end else if (is_trg) begin
            trig_pulse_q <= 1'b1;
            if (!cont_trig_q) begin
              st_q <= ST_IDLE;
              waiting_for_trigger_flag_q <= 1'b0;
            end
          end else if (done_rise && !cont_trig_q) begin
            st_q <= ST_IDLE;
            waiting_for_trigger_flag_q <= 1'b0;
          end
        end
        default: begin
          st_q <= ST_IDLE;
          waiting_for_trigger_flag_q <= 1'b0;
        end
      endcase
      if (!is_abort && st_q == ST_IDLE && cont_trig_q) begin
        waiting_for_trigger_flag_q <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // Output state, contrast and display
  // -----------------------------------------------------------------
  // Display mode, user text, contrast with non-volatile write strobe
  // The error and store pulses are cleared each cycle and raised only
  // by the command that causes them.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      output_on_q <= 1'b0;
      display_text_mode_q <= `TDC_ANS_NORMAL;
      contrast_q <= `TDC_RST_CONTRAST;
      nv_write_q <= 1'b0;
      user_text_q <= 128'h0;
      display_line_q <= 128'h0;
      text_answer_q <= 128'h0;
      text_quoted_q <= 1'b0;
      cmd_error_q <= 1'b0;
    end else if (clk_en) begin
      nv_write_q <= 1'b0;
      cmd_error_q <= 1'b0;
      if (do_cmd && (op_is(cmd_op, `TDC_OP_OUTSTAT) ||
                     op_is(cmd_op, `TDC_OP_INSTSTAT))) begin
        output_on_q <= cmd_arg[0];
      end
      if (do_cmd && op_is(cmd_op, `TDC_OP_CONTRAST)) begin
        // Tenths and integer forms both carry digit 0..9
        if (cmd_arg[15:4] == 12'h000 &&
            cmd_arg[3:0] <= `TDC_CON_MAX) begin
          contrast_q <= cmd_arg[3:0];
          nv_write_q <= 1'b1;
        end else begin
          cmd_error_q <= 1'b1;
        end
      end
      if (do_cmd && op_is(cmd_op, `TDC_OP_DMODE)) begin
        if (cmd_arg == `TDC_ARG_TEXT) begin
          display_text_mode_q <= `TDC_ANS_TEXT;
        end else if (cmd_arg == `TDC_ARG_NORMAL) begin
          display_text_mode_q <= `TDC_ANS_NORMAL;
        end else begin
          cmd_error_q <= 1'b1;
        end
      end
      if (do_cmd && op_is(cmd_op, `TDC_OP_RESET)) begin
        display_text_mode_q <= `TDC_ANS_NORMAL;
      end
      if (do_cmd && op_is(cmd_op, `TDC_OP_DTEXT)) begin
        user_text_q <= text_kept;
      end
      // Second line follows the mode; text only shown in text mode
      if (display_text_mode_q == `TDC_ANS_TEXT) begin
        display_line_q <= user_text_q;
        text_answer_q <= user_text_q;
        text_quoted_q <= 1'b1;
      end else begin
        display_line_q <= meter_hold_q;
        text_answer_q <= meter_hold_q;
        text_quoted_q <= 1'b0;
      end
    end
  end

endmodule // tdc_cmd_handler
